/* ldpd_chan.sv */
// Purpose: One LED output: duty compare, state select, polarity and drive.
// Assumes: Phase and group gate come from the shared counters.
// Notes:   Logical on means the pin sinks current when not inverted.
`timescale 1ns/1ns
module ldpd_chan (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Timing
  input  wire logic [7:0] phase_i,    // Individual PWM phase
  input  wire logic       dim_i,      // Group dimming selected
  input  wire logic       grp_on_i,   // Group waveform level
  input  wire logic       hold_i,     // Oscillator stopped
  // Settings
  input  wire logic [7:0] duty_i,     // Active brightness value
  input  wire logic [1:0] field_i,    // Active state field
  input  wire logic       inv_i,      // Output polarity invert
  input  wire logic       totem_i,    // Totem-pole drive
  // Pin
  output logic            led_o,
  output logic            led_oe_o
);
  import ldpd_pkg::*;

  typedef struct packed {
    logic on;    // Logical LED state
    logic out;   // Pin output value
    logic oe;    // Pin output enable
  } ldpd_chan_s;

  ldpd_chan_s s_q, s_d;
  logic       ind_on;   // Individual waveform level
  logic       pin_lvl;  // Electrical level wanted on the pin

  // Output logic
  always_comb begin
    s_d = s_q;
    // Count below duty keeps the output asserted from period start
    // Only group-controlled outputs take the fast rate while dimming
    if (dim_i && field_i == LS_GRP) begin
      ind_on = phase_i[5:0] < duty_i[7:2];  // Six bits at the fast rate
    end else begin
      ind_on = phase_i < duty_i;            // Full eight bits
    end
    if (!hold_i) begin                      // Frozen while asleep
      case (ldpd_led_state_e'(field_i))
        LS_OFF:  s_d.on = 1'b0;
        LS_ON:   s_d.on = 1'b1;
        LS_IND:  s_d.on = ind_on;
        LS_GRP:  s_d.on = ind_on & grp_on_i;
        default: s_d.on = 1'b0;
      endcase
    end
    // Lit means low when not inverted
    pin_lvl = ~s_d.on ^ inv_i;
    if (totem_i) begin                      // Drive both levels
      s_d.out = pin_lvl;
      s_d.oe  = 1'b1;
    end else begin                          // Sink only, release for high
      s_d.out = 1'b0;
      s_d.oe  = ~pin_lvl;
    end
  end

  // State register; pins released during reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign led_o    = s_q.out;
  assign led_oe_o = s_q.oe;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  property p_off_field;
    !hold_i && field_i == 2'b00 |=> !s_q.on;
  endproperty
  a_off_field: assert property (p_off_field)
    else $error("off field left output on");

  property p_on_field;
    !hold_i && field_i == 2'b01 |=> s_q.on;
  endproperty
  a_on_field: assert property (p_on_field)
    else $error("on field left output off");

  property p_totem;
    totem_i |=> led_oe_o;
  endproperty
  a_totem: assert property (p_totem)
    else $error("totem pole not driving");

  property p_opendrain;
    !totem_i |=> !led_o;
  endproperty
  a_opendrain: assert property (p_opendrain)
    else $error("open drain drove high");

  property p_invert;
    1'b1 |=> (s_q.oe && led_o == (~s_q.on ^ $past(inv_i))) || !$past(totem_i);
  endproperty
  a_invert: assert property (p_invert)
    else $error("polarity wrong on totem pin");

endmodule

/* ldpd_dimmer.sv */
// Behaviour
// - Config bit 5 picks dimming or blinking.
// - Config bit 4 inverts all outputs.
// - Config bit 3 picks STOP or ACK update.
// - Deferred update covers only addresses 02h-08h.
// - Config bit 2 picks open-drain or totem-pole.
// - Individual mode: 1.5625 kHz, duty value/256.
// - Dimming: field 11 outputs at 6.25 kHz, upper six bits only.
// - Blinking: 1.5625 kHz, all eight bits.
// - Dimming gates with fixed 190 Hz group wave.
// - Dimming group duty uses upper four bits.
// - Blinking: duty sets ratio, period sets period.
// - Fast blink uses upper six duty bits.
// - Slow blink uses all eight duty bits.
// - Blink period is (value+1)/24 seconds.
// - State register: four 2-bit fields, reset 00.
// - Field 00 holds output off.
// - Field 01 holds output fully on.
// - Field 10: individual waveform only.
// - Field 11: individual gated by group.
// - Low power freezes all outputs; config writes still change polarity and drive at once.
//
// Purpose: Four-channel LED PWM engine with group dimming and blinking.
// Assumes: Byte writes arrive already decoded from the serial slave; the
//          slave flags the acknowledge and STOP of each transfer as pulses.
// Notes:   Reads return the staged contents, not the active copies.
`timescale 1ns/1ns
module ldpd_dimmer (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Register write port
  input  wire logic       wr_en_i,
  input  wire logic [3:0] wr_addr_i,
  input  wire logic [7:0] wr_data_i,
  // Register read port
  input  wire logic [3:0] rd_addr_i,
  output logic      [7:0] rd_data_o,
  // Transfer events
  input  wire logic       bus_ack_i,
  input  wire logic       bus_stop_i,
  // Oscillator stopped by low-power bit
  input  wire logic       low_power_i,
  // LED pins
  output logic      [ldpd_pkg::LED_CNT-1:0] led_o,
  output logic      [ldpd_pkg::LED_CNT-1:0] led_oe_o
);
  import ldpd_pkg::*;

  typedef struct packed {
    logic                    grp_fn;     // 1 = blinking
    logic                    inv;        // Output polarity invert
    logic                    upd_ack;    // 1 = update on acknowledge
    logic                    drv;        // 1 = totem pole
    logic [1:0]              unused;     // Unused low field
    logic [LED_CNT-1:0][7:0] sh_bright;  // Staged brightness
    logic [7:0]              sh_gduty;   // Staged group duty
    logic [7:0]              sh_gper;    // Staged group period
    logic [7:0]              sh_state;   // Staged state fields
    logic [LED_CNT-1:0][7:0] act_bright; // Active brightness
    logic [7:0]              act_gduty;  // Active group duty
    logic [7:0]              act_gper;   // Active group period
    logic [7:0]              act_state;  // Active state fields
    logic [7:0]              ind_phase;  // Individual PWM phase
    logic [7:0]              grp_phase;  // Group waveform phase
    logic [7:0]              blk_cnt;    // Blink steps prescale
    logic                    grp_on;     // Group waveform level
    logic [7:0]              rd_data;    // Read data
  } ldpd_top_s;

  ldpd_top_s s_q, s_d;

  logic       ind_tick;    // Individual step
  logic       dim_tick;    // Group dimming step
  logic       blink_tick;  // Base blink step
  logic       upd_pt;      // Selected update point
  logic [7:0] gduty_eff;   // Group duty at the active resolution

  // Individual steps; both individual rates share one step length
  ldpd_tick #(.DIV(IND_STEP_CYC)) u_ind_tick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .hold_i    (low_power_i),
    .tick_o    (ind_tick)
  );

  // Group dimming steps at the fixed group rate
  ldpd_tick #(.DIV(GRP_STEP_CYC)) u_dim_tick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .hold_i    (low_power_i),
    .tick_o    (dim_tick)
  );

  // Blink base steps for a period value of zero
  ldpd_tick #(.DIV(BLINK_STEP_CYC)) u_blink_tick (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .hold_i    (low_power_i),
    .tick_o    (blink_tick)
  );

  // Update point chosen by the config bit
  assign upd_pt = s_q.upd_ack ? bus_ack_i : bus_stop_i;

  // Next-state logic
  always_comb begin
    s_d = s_q;

    // Register writes; config is immediate, 02h-08h go to staging
    if (wr_en_i) begin
      case (wr_addr_i)
        ADDR_CFG: begin
          s_d.grp_fn  = wr_data_i[CFG_GRP_FN_BIT];
          s_d.inv     = wr_data_i[CFG_INV_BIT];
          s_d.upd_ack = wr_data_i[CFG_UPD_BIT];
          s_d.drv     = wr_data_i[CFG_DRV_BIT];
          s_d.unused  = wr_data_i[1:0];
        end
        ADDR_GDUTY: s_d.sh_gduty = wr_data_i;
        ADDR_GPER:  s_d.sh_gper  = wr_data_i;
        ADDR_STATE: s_d.sh_state = wr_data_i;
        default: begin
          if (wr_addr_i >= ADDR_LED0 && wr_addr_i <= ADDR_LED3) begin
            s_d.sh_bright[2'(wr_addr_i - ADDR_LED0)] = wr_data_i;
          end
        end
      endcase
    end

    // Staged settings reach the PWM logic only at the update point
    if (upd_pt) begin
      s_d.act_bright = s_d.sh_bright;
      s_d.act_gduty  = s_d.sh_gduty;
      s_d.act_gper   = s_d.sh_gper;
      s_d.act_state  = s_d.sh_state;
    end

    // Individual phase wraps every 256 steps; a tick in flight at sleep is dropped
    if (ind_tick && !low_power_i) begin
      s_d.ind_phase = s_q.ind_phase + 8'h01;
    end

    // Group phase: fixed rate when dimming, period-scaled when blinking
    if (!s_q.grp_fn) begin
      if (dim_tick && !low_power_i) begin
        s_d.grp_phase = s_q.grp_phase + 8'h01;
      end
      s_d.blk_cnt = 8'h00;
    end else if (blink_tick && !low_power_i) begin
      // Each phase step lasts value+1 base steps
      if (s_q.blk_cnt >= s_q.act_gper) begin
        s_d.blk_cnt   = 8'h00;
        s_d.grp_phase = s_q.grp_phase + 8'h01;
      end else begin
        s_d.blk_cnt = s_q.blk_cnt + 8'h01;
      end
    end

    // Group duty resolution depends on mode and blink rate
    if (!s_q.grp_fn) begin
      gduty_eff = {s_q.act_gduty[7:4], 4'h0};
    end else if (s_q.act_gper < BLINK_FINE_FROM) begin
      gduty_eff = {s_q.act_gduty[7:2], 2'h0};
    end else begin
      gduty_eff = s_q.act_gduty;
    end
    if (!low_power_i) begin
      s_d.grp_on = s_q.grp_phase < gduty_eff;
    end

    // Read data from the staged register contents
    case (rd_addr_i)
      ADDR_CFG:   s_d.rd_data = {2'h0, s_q.grp_fn, s_q.inv, s_q.upd_ack, s_q.drv,
                                 s_q.unused};
      ADDR_GDUTY: s_d.rd_data = s_q.sh_gduty;
      ADDR_GPER:  s_d.rd_data = s_q.sh_gper;
      ADDR_STATE: s_d.rd_data = s_q.sh_state;
      default: begin
        if (rd_addr_i >= ADDR_LED0 && rd_addr_i <= ADDR_LED3) begin
          s_d.rd_data = s_q.sh_bright[2'(rd_addr_i - ADDR_LED0)];
        end else begin
          s_d.rd_data = RD_NONE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q            <= '0;
      s_q.unused     <= CFG_UNUSED_RST;
      s_q.sh_bright  <= {LED_CNT{BRIGHT_RST}};
      s_q.act_bright <= {LED_CNT{BRIGHT_RST}};
      s_q.sh_gduty   <= GDUTY_RST;
      s_q.act_gduty  <= GDUTY_RST;
      s_q.sh_gper    <= GPER_RST;
      s_q.act_gper   <= GPER_RST;
      s_q.sh_state   <= STATE_RST;
      s_q.act_state  <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_o = s_q.rd_data;

  // One output stage per LED
  for (genvar gi = 0; gi < LED_CNT; gi++) begin : g_chan
    ldpd_chan u_chan (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .phase_i   (s_q.ind_phase),
      .dim_i     (~s_q.grp_fn),
      .grp_on_i  (s_q.grp_on),
      .hold_i    (low_power_i),
      .duty_i    (s_q.act_bright[gi]),
      .field_i   (s_q.act_state[2*gi +: 2]),
      .inv_i     (s_q.inv),
      .totem_i   (s_q.drv),
      .led_o     (led_o[gi]),
      .led_oe_o  (led_oe_o[gi])
    );
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stop_point;
    !s_q.upd_ack && bus_stop_i;
  endsequence

  sequence s_ack_point;
    s_q.upd_ack && bus_ack_i;
  endsequence

  property p_stop_xfer;
    s_stop_point |=> s_q.act_state == s_q.sh_state && s_q.act_gduty == s_q.sh_gduty;
  endproperty
  a_stop_xfer: assert property (p_stop_xfer)
    else $error("stop did not transfer staged settings");

  property p_ack_xfer;
    s_ack_point |=> s_q.act_bright == s_q.sh_bright && s_q.act_gper == s_q.sh_gper;
  endproperty
  a_ack_xfer: assert property (p_ack_xfer)
    else $error("ack did not transfer staged settings");

  property p_no_xfer;
    !upd_pt |=> $stable(s_q.act_bright) && $stable(s_q.act_state);
  endproperty
  a_no_xfer: assert property (p_no_xfer)
    else $error("active settings changed outside update point");

  property p_cfg_now;
    wr_en_i && wr_addr_i == ADDR_CFG |=> s_q.grp_fn == $past(wr_data_i[CFG_GRP_FN_BIT])
      ##1 rd_addr_i != ADDR_CFG || rd_data_o[7:6] == 2'h0;
  endproperty
  a_cfg_now: assert property (p_cfg_now)
    else $error("config write not applied at once");

  property p_dim_gate;
    !s_q.grp_fn && !low_power_i && s_q.act_gduty[7:4] == 4'h0 |=> !s_q.grp_on;
  endproperty
  a_dim_gate: assert property (p_dim_gate)
    else $error("group gate open at zero dimming duty");

  property p_freeze;
    low_power_i |=> $stable(s_q.ind_phase) && $stable(s_q.grp_on);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("timing advanced while asleep");

  // Counter steps; a tick in flight while asleep must not advance them
  property p_ind_step;
    ind_tick && !low_power_i |=> s_q.ind_phase == $past(s_q.ind_phase) + 8'h01;
  endproperty
  a_ind_step: assert property (p_ind_step)
    else $error("individual phase missed a step");

  property p_ind_hold;
    !ind_tick |=> $stable(s_q.ind_phase);
  endproperty
  a_ind_hold: assert property (p_ind_hold)
    else $error("individual phase moved without a tick");

  property p_dim_step;
    !s_q.grp_fn && dim_tick && !low_power_i
      |=> s_q.grp_phase == $past(s_q.grp_phase) + 8'h01;
  endproperty
  a_dim_step: assert property (p_dim_step)
    else $error("dimming phase missed a step");

  sequence s_blink_wrap;
    s_q.grp_fn && blink_tick && !low_power_i && s_q.blk_cnt >= s_q.act_gper;
  endsequence

  property p_blink_step;
    s_blink_wrap |=> s_q.grp_phase == $past(s_q.grp_phase) + 8'h01 && s_q.blk_cnt == 8'h00;
  endproperty
  a_blink_step: assert property (p_blink_step)
    else $error("blink phase did not step after period count");

  // Group duty resolution: coarse steps drop the low bits
  sequence s_fast_blink;
    s_q.grp_fn && !low_power_i && s_q.act_gper < BLINK_FINE_FROM;
  endsequence

  property p_fast_coarse;
    s_fast_blink ##0 s_q.grp_phase[7:2] == s_q.act_gduty[7:2] |=> !s_q.grp_on;
  endproperty
  a_fast_coarse: assert property (p_fast_coarse)
    else $error("fast blink used low duty bits");

  property p_slow_fine;
    s_q.grp_fn && !low_power_i && s_q.act_gper >= BLINK_FINE_FROM
      && s_q.grp_phase < s_q.act_gduty |=> s_q.grp_on;
  endproperty
  a_slow_fine: assert property (p_slow_fine)
    else $error("slow blink lost low duty bits");

  property p_dim_coarse;
    !s_q.grp_fn && !low_power_i && s_q.grp_phase[7:4] == s_q.act_gduty[7:4]
      |=> !s_q.grp_on;
  endproperty
  a_dim_coarse: assert property (p_dim_coarse)
    else $error("dimming used low group duty bits");

  // Config and staging writes land on the next edge
  property p_cfg_fields;
    wr_en_i && wr_addr_i == ADDR_CFG
      |=> s_q.inv == $past(wr_data_i[CFG_INV_BIT])
      && s_q.drv == $past(wr_data_i[CFG_DRV_BIT])
      && s_q.upd_ack == $past(wr_data_i[CFG_UPD_BIT]);
  endproperty
  a_cfg_fields: assert property (p_cfg_fields)
    else $error("config fields not applied at once");

  property p_state_stage;
    wr_en_i && wr_addr_i == ADDR_STATE |=> s_q.sh_state == $past(wr_data_i);
  endproperty
  a_state_stage: assert property (p_state_stage)
    else $error("state write not staged");

endmodule

/* ldpd_dimmer_tb.sv */
// Purpose: Self-checking bench for the four-channel LED dimmer.
// Assumes: Open-drain, non-inverted pins except where a test changes it.
// Notes:   Duty is judged by counting lit cycles over whole PWM periods.
`timescale 1ns/1ns
module ldpd_dimmer_tb;
  import ldpd_pkg::*;
  // Clock, reset and design signals
  logic                sys_clk_i;
  logic                rst_i;
  logic                wr_en;
  logic [3:0]          wr_addr;
  logic [7:0]          wr_data;
  logic                ack;
  logic                stop;
  logic                low_power;
  logic [3:0]          rd_addr_i;
  logic [7:0]          rd_data_o;
  logic [LED_CNT-1:0]  led_o;
  logic [LED_CNT-1:0]  led_oe_o;
  int                  errors;
  int                  num_checks;

  ldpd_master_model ldpd_master_model_inst (
    .sys_clk_i   (sys_clk_i),
    .wr_en_o     (wr_en),
    .wr_addr_o   (wr_addr),
    .wr_data_o   (wr_data),
    .ack_o       (ack),
    .stop_o      (stop),
    .low_power_o (low_power)
  );

  ldpd_dimmer ldpd_dimmer_inst (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .wr_en_i     (wr_en),
    .wr_addr_i   (wr_addr),
    .wr_data_i   (wr_data),
    .rd_addr_i   (rd_addr_i),
    .rd_data_o   (rd_data_o),
    .bus_ack_i   (ack),
    .bus_stop_i  (stop),
    .low_power_i (low_power),
    .led_o       (led_o),
    .led_oe_o    (led_oe_o)
  );

  // 100 ns clock
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Compare and count
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Registered read port: answer lands one edge after the address
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    rd_addr_i <= a;
    repeat (2) @(posedge sys_clk_i);
    #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd_data_o});
  endtask

  // Let an update reach the pins, then sample settled values
  task automatic settle();
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask

  // Lit cycles of one open-drain output over n cycles
  task automatic lit(input int i, input int n, output logic [15:0] c);
    c = 16'h0000;
    repeat (n) begin
      @(posedge sys_clk_i);
      #1 c = c + {15'h0000, led_oe_o[i] === 1'b1};
    end
  endtask

  // Reset values of every register and unmapped places
  task automatic t_reset();
    logic [7:0] e [0:9];
    e = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    chk("oe", 16'h0000, {12'h000, led_oe_o});
    for (int a = 0; a < 10; a++) begin
      rd(a[3:0], e[a]);
    end
    $display("test reset done");
  endtask

  // Config fields read back and act at once, without an update point
  task automatic t_cfg();
    ldpd_master_model_inst.put(4'h1, 8'hFF);
    rd(4'h1, 8'h3F);
    ldpd_master_model_inst.put(4'h1, 8'h11);
    settle();
    chk("oe inv", 16'h000F, {12'h000, led_oe_o});
    ldpd_master_model_inst.put(4'h1, 8'h01);
    settle();
    chk("oe plain", 16'h0000, {12'h000, led_oe_o});
    $display("test cfg done");
  endtask

  // STOP versus ACK update points, then totem-pole levels
  task automatic t_update();
    ldpd_master_model_inst.put(4'h8, 8'h55);
    settle();
    chk("oe before stop", 16'h0000, {12'h000, led_oe_o});
    ldpd_master_model_inst.stop();
    settle();
    chk("oe after stop", 16'h000F, {12'h000, led_oe_o});
    chk("led od", 16'h0000, {12'h000, led_o});
    ldpd_master_model_inst.put(4'h1, 8'h09);
    ldpd_master_model_inst.put(4'h8, 8'h00);
    settle();
    chk("oe after ack", 16'h0000, {12'h000, led_oe_o});
    ldpd_master_model_inst.put(4'h1, 8'h0D);
    settle();
    chk("oe totem", 16'h000F, {12'h000, led_oe_o});
    chk("led off", 16'h000F, {12'h000, led_o});
    ldpd_master_model_inst.put(4'h8, 8'h55);
    settle();
    chk("led on", 16'h0000, {12'h000, led_o});
    ldpd_master_model_inst.put(4'h1, 8'h1D);
    settle();
    chk("led on inv", 16'h000F, {12'h000, led_o});
    ldpd_master_model_inst.put(4'h1, 8'h09);
    $display("test update done");
  endtask

  // Individual PWM: 25 cycles a step, 6400 a period, all eight bits
  task automatic t_ind();
    logic [15:0] c;
    ldpd_master_model_inst.put(4'h1, 8'h29);
    ldpd_master_model_inst.put(4'h2, 8'h81);
    ldpd_master_model_inst.put(4'h8, 8'h02);
    settle();
    lit(0, 6400, c);
    chk("duty 81", 16'd3225, c);
    lit(1, 6400, c);
    chk("led1 off", 16'd0, c);
    ldpd_master_model_inst.put(4'h2, 8'h00);
    settle();
    lit(0, 6400, c);
    chk("duty 00", 16'd0, c);
    $display("test ind done");
  endtask

  // Group dimming drops low bits; group only touches field 11
  task automatic t_dim();
    logic [15:0] c;
    ldpd_master_model_inst.put(4'h1, 8'h09);
    ldpd_master_model_inst.put(4'h2, 8'h03);
    ldpd_master_model_inst.put(4'h6, 8'hFF);
    ldpd_master_model_inst.put(4'h8, 8'h03);
    settle();
    lit(0, 3200, c);
    chk("dim low bits", 16'd0, c);
    ldpd_master_model_inst.put(4'h2, 8'hFF);
    ldpd_master_model_inst.put(4'h6, 8'h0F);
    settle();
    lit(0, 3200, c);
    chk("group low bits", 16'd0, c);
    ldpd_master_model_inst.put(4'h8, 8'h02);
    settle();
    lit(0, 6400, c);
    chk("ind ignores group", 16'd6375, c);
    $display("test dim done");
  endtask

  // Fast blink drops the two low duty bits
  task automatic t_blink();
    logic [15:0] c;
    ldpd_master_model_inst.put(4'h1, 8'h29);
    ldpd_master_model_inst.put(4'h7, 8'h00);
    ldpd_master_model_inst.put(4'h6, 8'h03);
    ldpd_master_model_inst.put(4'h8, 8'h03);
    settle();
    lit(0, 6400, c);
    chk("blink low bits", 16'd0, c);
    rd(4'h7, 8'h00);
    $display("test blink done");
  endtask

  // Low power freezes pins even across a state change
  task automatic t_lp();
    logic [3:0]  o;
    logic [15:0] c;
    ldpd_master_model_inst.put(4'h1, 8'h09);
    ldpd_master_model_inst.put(4'h2, 8'h80);
    ldpd_master_model_inst.put(4'h8, 8'h02);
    ldpd_master_model_inst.sleep(1'b1);
    settle();
    o = led_oe_o;
    ldpd_master_model_inst.put(4'h8, 8'h01);
    c = 16'h0000;
    repeat (500) begin
      @(posedge sys_clk_i);
      #1 c = c + {15'h0000, led_oe_o !== o};
    end
    chk("frozen", 16'd0, c);
    ldpd_master_model_inst.sleep(1'b0);
    settle();
    chk("awake on", 16'h0001, {12'h000, led_oe_o});
    $display("test lp done");
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #10_000_000;
    errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    errors = 0;
    num_checks = 0;
    rst_i = 1'b1;
    rd_addr_i = 4'h0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle();
    t_reset();
    t_cfg();
    t_update();
    t_ind();
    t_dim();
    t_blink();
    t_lp();
    end_of_test();
  end
endmodule

/* ldpd_master_model.sv */
// Purpose: Register-writing master on the far side of the dimmer.
// Assumes: One byte per write, acknowledge pulse one cycle later.
// Notes:   Released write lines show the inverse of the last byte.
`timescale 1ns/1ns
module ldpd_master_model (
  // Clock
  input  wire logic       sys_clk_i,
  // Write port and events
  output logic            wr_en_o,
  output logic      [3:0] wr_addr_o,
  output logic      [7:0] wr_data_o,
  output logic            ack_o,
  output logic            stop_o,
  // Low-power bit
  output logic            low_power_o
);
  // Idle bus at time zero
  initial begin
    wr_en_o = 1'b0;
    wr_addr_o = 4'h0;
    wr_data_o = 8'h00;
    ack_o = 1'b0;
    stop_o = 1'b0;
    low_power_o = 1'b0;
  end

  // One byte, then its acknowledge; inverse shown so stale data is never reused
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr_en_o <= 1'b1;
    wr_addr_o <= a;
    wr_data_o <= d;
    @(posedge sys_clk_i);
    wr_en_o <= 1'b0;
    wr_addr_o <= ~a;
    wr_data_o <= ~d;
    ack_o <= 1'b1;
    @(posedge sys_clk_i);
    ack_o <= 1'b0;
  endtask

  // STOP condition pulse
  task automatic stop();
    @(posedge sys_clk_i);
    stop_o <= 1'b1;
    @(posedge sys_clk_i);
    stop_o <= 1'b0;
  endtask

  // Sleep control; waking waits out the oscillator start before returning
  task automatic sleep(input logic on);
    @(posedge sys_clk_i);
    low_power_o <= on;
    if (!on) begin
      repeat (5000) @(posedge sys_clk_i);
    end
  endtask
endmodule

/* ldpd_pkg.sv */
// Purpose: Shared constants and types for the four-channel LED dimmer.
// Assumes: 10 MHz system clock; register port is a byte-wide write/read port.
// Notes:   All timing counts are derived from the clock rate below.
package ldpd_pkg;

  // Register addresses
  localparam logic [3:0] ADDR_CFG    = 4'h1;   // Output configuration
  localparam logic [3:0] ADDR_LED0   = 4'h2;   // First brightness register
  localparam logic [3:0] ADDR_LED3   = 4'h5;   // Last brightness register
  localparam logic [3:0] ADDR_GDUTY  = 4'h6;   // Group duty
  localparam logic [3:0] ADDR_GPER   = 4'h7;   // Group period
  localparam logic [3:0] ADDR_STATE  = 4'h8;   // LED state select

  // Output configuration field positions
  localparam int CFG_GRP_FN_BIT = 5;           // Group function select
  localparam int CFG_INV_BIT    = 4;           // Output polarity invert
  localparam int CFG_UPD_BIT    = 3;           // Output update point
  localparam int CFG_DRV_BIT    = 2;           // Output drive type

  // Reset values
  localparam logic [1:0] CFG_UNUSED_RST = 2'h1;  // Unused low field
  localparam logic [7:0] BRIGHT_RST     = 8'h00;
  localparam logic [7:0] GDUTY_RST      = 8'hFF;
  localparam logic [7:0] GPER_RST       = 8'h00;
  localparam logic [7:0] STATE_RST      = 8'h00;
  localparam logic [7:0] RD_NONE        = 8'h00;  // Unmapped read value

  // Timing
  localparam longint CLK_HZ           = 10_000_000;
  localparam longint IND_FREQ_MHZ     = 1_562_500;   // 1.5625 kHz, in mHz
  localparam longint IND_STEPS        = 256;
  localparam longint DIM_FREQ_MHZ     = 6_250_000;   // 6.25 kHz, in mHz
  localparam longint DIM_STEPS        = 64;
  localparam longint GRP_DIM_HZ       = 190;
  localparam longint GRP_STEPS        = 256;
  localparam longint BLINK_DIV        = 24;          // Period = (value+1)/24 s

  // Cycles per individual PWM step; equal for both individual rates
  localparam logic [11:0] IND_STEP_CYC =
    12'(CLK_HZ * 1000 / (IND_FREQ_MHZ * IND_STEPS));
  localparam logic [11:0] DIM_STEP_CYC =
    12'(CLK_HZ * 1000 / (DIM_FREQ_MHZ * DIM_STEPS));
  // Cycles per group dimming step
  localparam logic [11:0] GRP_STEP_CYC = 12'(CLK_HZ / (GRP_DIM_HZ * GRP_STEPS));
  // Cycles per blink step for a period value of zero
  localparam logic [11:0] BLINK_STEP_CYC = 12'(CLK_HZ / (BLINK_DIV * GRP_STEPS));
  // Period values at or above this blink at 6 Hz or slower
  localparam logic [7:0] BLINK_FINE_FROM = 8'h03;

  localparam int LED_CNT = 4;

  // Per-output state field
  typedef enum logic [1:0] {
    LS_OFF = 2'b00,   // Held off
    LS_ON  = 2'b01,   // Fully on
    LS_IND = 2'b10,   // Individual PWM only
    LS_GRP = 2'b11    // Individual and group
  } ldpd_led_state_e;

endpackage

/* ldpd_tick.sv */
// Purpose: Step prescaler producing a one-cycle tick every DIV cycles.
// Assumes: DIV is at least 2.
// Notes:   Holding freezes the count so timing resumes where it stopped.
`timescale 1ns/1ns
module ldpd_tick #(
  parameter logic [11:0] DIV = 12'h019
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic hold_i,
  // Tick
  output logic      tick_o
);
  import ldpd_pkg::*;

  typedef struct packed {
    logic [11:0] cnt;   // Cycles into the step
    logic        tick;  // Step boundary pulse
  } ldpd_tick_s;

  ldpd_tick_s s_q, s_d;

  // Count to DIV-1 then wrap with a tick
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!hold_i) begin
      if (s_q.cnt == DIV - 12'h001) begin
        s_d.cnt  = 12'h000;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 12'h001;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule
